// File: verilog/lsp_led_sink_pwm_control.sv
// module: control of three led current sinks with ramping and pwm dimming
//
// Contract
// - clearing a sink enable clears its loop include
// - ramp bit steps current one code per ms
// - channel three without current control is pwm-only
// - shared idle code feeds channels one and two, and channel three with current control
// - codes map logarithmically, 50 uA to 26 mA
// - 7-bit duty, period 95 ticks of 2 MHz
// - zero off, 95 or above always on
// - own code during duty, idle code otherwise
// - dim bit steps duty once per 40 ms
// - loop include bit selects boost regulation input
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module lsp_led_sink_pwm_control #(
  parameter int PRESCALE_CYC  = lsp_pkg::PRESCALE,
  parameter int RAMP_TICKS_2M = lsp_pkg::RAMP_TICKS,
  parameter int DIM_TICKS_2M  = lsp_pkg::DIM_TICKS
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire lsp_pkg::lsp_bus_req_t       bus_req,
  output logic [lsp_pkg::DATA_W-1:0]       rdata,
  input  wire logic                        sink3_pwm_phase,
  output logic                             boost_current_mode,
  output lsp_pkg::lsp_sink_t               sink1_out,
  output lsp_pkg::lsp_sink_t               sink2_out,
  output lsp_pkg::lsp_sink_t               sink3_out
);

  localparam int PS_W   = $clog2(PRESCALE_CYC);
  localparam int RMP_W  = $clog2(RAMP_TICKS_2M);
  localparam int DIM_W  = $clog2(DIM_TICKS_2M);
  localparam int CODE_W = lsp_pkg::CODE_W;
  localparam int DUTY_W = lsp_pkg::DUTY_W;
  localparam int NUM_CH = lsp_pkg::NUM_CH;

  // ---- tick generation
  logic [PS_W-1:0]  ps_cnt_reg;
  logic [PS_W-1:0]  ps_cnt_next;
  logic [RMP_W-1:0] ms_cnt_reg;
  logic [RMP_W-1:0] ms_cnt_next;
  logic [DIM_W-1:0] dim_cnt_reg;
  logic [DIM_W-1:0] dim_cnt_next;
  logic             tick_2m;
  logic             ms_tick;
  logic             dim_tick;

  // 200 MHz divided down to 2 MHz, then to 1 ms and 40 ms
  assign tick_2m      = (ps_cnt_reg == PS_W'(PRESCALE_CYC - 1));
  assign ps_cnt_next  = tick_2m ? '0 : ps_cnt_reg + PS_W'(1);
  assign ms_tick      = tick_2m && (ms_cnt_reg == RMP_W'(RAMP_TICKS_2M - 1));
  assign dim_tick     = tick_2m && (dim_cnt_reg == DIM_W'(DIM_TICKS_2M - 1));
  assign ms_cnt_next  = ms_tick ? '0 : tick_2m ? ms_cnt_reg + RMP_W'(1) : ms_cnt_reg;
  assign dim_cnt_next = dim_tick ? '0 : tick_2m ? dim_cnt_reg + DIM_W'(1) : dim_cnt_reg;

  // tick counters, cleared by reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ps_cnt_reg  <= '0;
      ms_cnt_reg  <= '0;
      dim_cnt_reg <= '0;
    end else begin
      ps_cnt_reg  <= ps_cnt_next;
      ms_cnt_reg  <= ms_cnt_next;
      dim_cnt_reg <= dim_cnt_next;
    end
  end

  // ---- register bus decode
  logic wr_sc;
  logic wr_idle;
  logic wr_code1;
  logic wr_code2;
  logic wr_code3;
  logic wr_pwm1;
  logic wr_pwm2;
  logic wr_loop;
  logic [lsp_pkg::ADDR_W-1:0] a;

  assign a        = bus_req.addr;
  assign wr_sc    = bus_req.wr && a == lsp_pkg::reg_addr(lsp_pkg::IDX_SINK_CONTROL);
  assign wr_idle  = bus_req.wr && a == lsp_pkg::reg_addr(lsp_pkg::IDX_IDLE_CODE);
  assign wr_code1 = bus_req.wr && a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH1_CODE);
  assign wr_code2 = bus_req.wr && a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH2_CODE);
  assign wr_code3 = bus_req.wr && a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH3_CODE);
  assign wr_pwm1  = bus_req.wr && a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH1_PWM);
  assign wr_pwm2  = bus_req.wr && a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH2_PWM);
  assign wr_loop  = bus_req.wr && a == lsp_pkg::reg_addr(lsp_pkg::IDX_LOOP_INCLUDE);

  // ---- software registers
  logic [7:0] sink_ctl_reg;
  logic [7:0] sink_ctl_next;
  logic [7:0] sc_wval;
  logic [7:0] idle_code_reg;
  logic [7:0] code_reg [NUM_CH];
  logic [7:0] pwm1_reg;
  logic [7:0] pwm2_reg;
  logic [2:0] loop_reg;
  logic [2:0] loop_next;
  logic [2:0] en_mask;

  // without current control, the channel three enable cannot be set
  assign sc_wval = bus_req.wdata[lsp_pkg::SC_ICONT3] ? bus_req.wdata :
                   (bus_req.wdata & ~(8'h01 << lsp_pkg::SC_EN3));
  assign sink_ctl_next = wr_sc ? sc_wval : sink_ctl_reg;

  // loop include bits follow the enables of the same cycle
  assign en_mask = {sink_ctl_next[lsp_pkg::SC_EN3],
                    sink_ctl_next[lsp_pkg::SC_EN2],
                    sink_ctl_next[lsp_pkg::SC_EN1]};
  assign loop_next = (wr_loop ? bus_req.wdata[2:0] : loop_reg) & en_mask;

  // register storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sink_ctl_reg  <= lsp_pkg::RST_SINK_CONTROL;
      idle_code_reg <= lsp_pkg::RST_CODE;
      code_reg[0]   <= lsp_pkg::RST_CODE;
      code_reg[1]   <= lsp_pkg::RST_CODE;
      code_reg[2]   <= lsp_pkg::RST_CODE;
      pwm1_reg      <= lsp_pkg::RST_PWM;
      pwm2_reg      <= lsp_pkg::RST_PWM;
      loop_reg      <= lsp_pkg::RST_LOOP;
    end else begin
      sink_ctl_reg <= sink_ctl_next;
      loop_reg     <= loop_next;
      if (wr_idle) begin
        idle_code_reg <= bus_req.wdata;
      end
      if (wr_code1) begin
        code_reg[0] <= bus_req.wdata;
      end
      if (wr_code2) begin
        code_reg[1] <= bus_req.wdata;
      end
      if (wr_code3) begin
        code_reg[2] <= bus_req.wdata;
      end
      if (wr_pwm1) begin
        pwm1_reg <= bus_req.wdata;
      end
      if (wr_pwm2) begin
        pwm2_reg <= bus_req.wdata;
      end
    end
  end

  // ---- current ramping
  logic [7:0] cur_reg  [NUM_CH];
  logic [7:0] cur_next [NUM_CH];
  logic [2:0] ramp_en;

  assign ramp_en = {sink_ctl_reg[lsp_pkg::SC_RAMP3],
                    sink_ctl_reg[lsp_pkg::SC_RAMP2],
                    sink_ctl_reg[lsp_pkg::SC_RAMP1]};

  // applied code: target at once, or one step per ms tick
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      cur_next[i] = !ramp_en[i] ? code_reg[i] :
                    ms_tick ? lsp_pkg::step_toward(cur_reg[i], code_reg[i]) :
                    cur_reg[i];
    end
  end

  // applied current codes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cur_reg[i] <= lsp_pkg::RST_CODE;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        cur_reg[i] <= cur_next[i];
      end
    end
  end

  // ---- pwm generators for channels one and two
  logic       pwm1_on;
  logic       pwm2_on;
  logic [6:0] duty1_now;

  lsp_pwm_channel #(.DUTY_W(DUTY_W)) u_pwm1 (
    .clk         (clk),
    .rstn        (rstn),
    .tick_2m     (tick_2m),
    .dim_tick    (dim_tick),
    .duty_target (pwm1_reg[DUTY_W-1:0]),
    .duty_ramp   (pwm1_reg[lsp_pkg::PC_DIM]),
    .pwm_on      (pwm1_on),
    .duty_now    (duty1_now)
  );

  lsp_pwm_channel #(.DUTY_W(DUTY_W)) u_pwm2 (
    .clk         (clk),
    .rstn        (rstn),
    .tick_2m     (tick_2m),
    .dim_tick    (dim_tick),
    .duty_target (pwm2_reg[DUTY_W-1:0]),
    .duty_ramp   (pwm2_reg[lsp_pkg::PC_DIM]),
    .pwm_on      (pwm2_on),
    .duty_now    ()
  );

  // ---- sink drive; codes go to the logarithmic current dacs
  logic       icont3;
  logic [7:0] drv1_next;
  logic [7:0] drv2_next;
  logic [7:0] drv3_next;
  lsp_pkg::lsp_sink_t s1_reg;
  lsp_pkg::lsp_sink_t s2_reg;
  lsp_pkg::lsp_sink_t s3_reg;

  assign icont3    = sink_ctl_reg[lsp_pkg::SC_ICONT3];
  assign drv1_next = pwm1_on ? cur_reg[0] : idle_code_reg;
  assign drv2_next = pwm2_on ? cur_reg[1] : idle_code_reg;
  assign drv3_next = !icont3 ? 8'h00 :
                     sink3_pwm_phase ? cur_reg[2] : idle_code_reg;

  // registered sink outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= '{sink_ctl_reg[lsp_pkg::SC_EN1], loop_reg[lsp_pkg::LI_CH1],
                  pwm1_on, drv1_next};
      s2_reg <= '{sink_ctl_reg[lsp_pkg::SC_EN2], loop_reg[lsp_pkg::LI_CH2],
                  pwm2_on, drv2_next};
      s3_reg <= '{sink_ctl_reg[lsp_pkg::SC_EN3] & icont3,
                  loop_reg[lsp_pkg::LI_CH3] & icont3,
                  sink3_pwm_phase, drv3_next};
    end
  end

  assign sink1_out          = s1_reg;
  assign sink2_out          = s2_reg;
  assign sink3_out          = s3_reg;
  assign boost_current_mode = sink_ctl_reg[lsp_pkg::SC_MODE];

  // ---- read path, data in the cycle after the strobe only
  logic [7:0] rd_mux;
  logic [7:0] rdata_reg;

  assign rd_mux =
    (a == lsp_pkg::reg_addr(lsp_pkg::IDX_SINK_CONTROL)) ? sink_ctl_reg  :
    (a == lsp_pkg::reg_addr(lsp_pkg::IDX_IDLE_CODE))    ? idle_code_reg :
    (a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH1_CODE))     ? code_reg[0]   :
    (a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH2_CODE))     ? code_reg[1]   :
    (a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH3_CODE))     ? code_reg[2]   :
    (a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH1_PWM))      ? pwm1_reg      :
    (a == lsp_pkg::reg_addr(lsp_pkg::IDX_CH2_PWM))      ? pwm2_reg      :
    (a == lsp_pkg::reg_addr(lsp_pkg::IDX_LOOP_INCLUDE)) ? {5'h00, loop_reg} :
    8'h00; // unmapped reads zero

  // read data register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  assign rdata = rdata_reg;

  // ---- checks
  a_en1_loop_clear: assert property (@(posedge clk) disable iff (!rstn)
    !sink_ctl_reg[lsp_pkg::SC_EN1] |-> !loop_reg[lsp_pkg::LI_CH1])
    else $error("loop include one set with sink one disabled");

  a_disable_clears: assert property (@(posedge clk) disable iff (!rstn)
    wr_sc && !bus_req.wdata[lsp_pkg::SC_EN2] |=> ##1 !sink2_out.loop_include)
    else $error("disabling sink two left loop include on");

  a_ramp_hold: assert property (@(posedge clk) disable iff (!rstn)
    ramp_en[0] && !ms_tick |=> $stable(cur_reg[0]))
    else $error("ramped current moved without a ms tick");

  a_ramp_step: assert property (@(posedge clk) disable iff (!rstn)
    ramp_en[0] && ms_tick && cur_reg[0] > code_reg[0]
    |=> cur_reg[0] == $past(cur_reg[0]) - 8'h01)
    else $error("ramped current did not step down by one");

  a_no_ramp_direct: assert property (@(posedge clk) disable iff (!rstn)
    !ramp_en[0] |=> cur_reg[0] == $past(code_reg[0]))
    else $error("unramped current did not apply at once");

  a_ch3_pwm_only: assert property (@(posedge clk) disable iff (!rstn)
    !icont3 |=> !sink3_out.sink_enable && !sink3_out.loop_include
                && sink3_out.drive_code == 8'h00)
    else $error("channel three not pwm-only without current control");

  a_dim_down_step: assert property (@(posedge clk) disable iff (!rstn)
    pwm1_reg[lsp_pkg::PC_DIM] && dim_tick && duty1_now > pwm1_reg[DUTY_W-1:0]
    |=> duty1_now == $past(duty1_now) - 7'h01)
    else $error("dimmed duty did not step down by one");

  a_idle_code: assert property (@(posedge clk) disable iff (!rstn)
    !pwm1_on |=> sink1_out.drive_code == $past(idle_code_reg))
    else $error("idle phase did not drive the shared idle code");

  a_ms_spacing: assert property (@(posedge clk) disable iff (!rstn)
    ms_tick |-> ms_cnt_reg == RMP_W'(RAMP_TICKS_2M - 1) && tick_2m)
    else $error("ms tick at the wrong count");

  a_prescale: assert property (@(posedge clk) disable iff (!rstn)
    tick_2m |=> !tick_2m)
    else $error("2 MHz tick lasted more than one cycle");

endmodule : lsp_led_sink_pwm_control

// File: verilog/lsp_pkg.sv
// package: register map, field layout, timing and carriers for the led sink pwm control
package lsp_pkg;

  // widths of bus and codes
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int CODE_W = 8;
  localparam int DUTY_W = 7;
  localparam int NUM_CH = 3;

  // register offsets, used directly as bus addresses
  localparam logic [7:0] IDX_SINK_CONTROL = 8'h47;
  localparam logic [7:0] IDX_IDLE_CODE    = 8'h48;
  localparam logic [7:0] IDX_CH1_CODE     = 8'h49;
  localparam logic [7:0] IDX_CH2_CODE     = 8'h4A;
  localparam logic [7:0] IDX_CH3_CODE     = 8'h4B;
  localparam logic [7:0] IDX_CH1_PWM      = 8'h4C;
  localparam logic [7:0] IDX_CH2_PWM      = 8'h4D;
  localparam logic [7:0] IDX_LOOP_INCLUDE = 8'h50;

  // sink_control field positions
  localparam int SC_EN1    = 0;
  localparam int SC_RAMP1  = 1;
  localparam int SC_EN2    = 2;
  localparam int SC_RAMP2  = 3;
  localparam int SC_EN3    = 4;
  localparam int SC_RAMP3  = 5;
  localparam int SC_ICONT3 = 6;
  localparam int SC_MODE   = 7;

  // pwm control and loop include field positions
  localparam int PC_DIM  = 7;
  localparam int LI_CH1  = 0;
  localparam int LI_CH2  = 1;
  localparam int LI_CH3  = 2;

  // reset values
  localparam logic [7:0] RST_SINK_CONTROL = 8'h00;
  localparam logic [7:0] RST_CODE         = 8'h00;
  localparam logic [7:0] RST_PWM          = 8'h00;
  localparam logic [2:0] RST_LOOP         = 3'h0;

  // clocks and pwm shape
  localparam longint CLK_HZ     = 200_000_000;
  localparam longint PWM_CLK_HZ = 2_000_000;
  localparam int PRESCALE       = int'(CLK_HZ / PWM_CLK_HZ);
  localparam logic [6:0] PWM_PERIOD = 7'h5F;
  localparam logic [6:0] DUTY_OFF   = 7'h00;

  // step times in their own units, then counts of 2 MHz ticks
  localparam longint RAMP_STEP_US = 1;
  localparam longint RAMP_STEP_MS = 1;
  localparam longint DIM_STEP_MS  = 40;
  localparam int RAMP_TICKS = int'(RAMP_STEP_MS * PWM_CLK_HZ / 1000);
  localparam int DIM_TICKS  = int'(DIM_STEP_MS * PWM_CLK_HZ / 1000);

  // analog end points of the logarithmic current code, in nA
  localparam int CURRENT_MIN_NA = 50_000;
  localparam int CURRENT_MAX_NA = 26_000_000;

  // register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lsp_bus_req_t;

  // per-channel sink drive towards the analog side
  typedef struct packed {
    logic              sink_enable;
    logic              loop_include;
    logic              pwm_on;
    logic [CODE_W-1:0] drive_code;
  } lsp_sink_t;

  // bus address of a register offset
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {1'b0, idx};
  endfunction : reg_addr

  // one step of a code toward its target
  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    logic [7:0] res;
    res = cur;
    if (cur < tgt) begin
      res = cur + 8'h01;
    end else if (cur > tgt) begin
      res = cur - 8'h01;
    end
    return res;
  endfunction : step_toward

endpackage : lsp_pkg

// File: verilog/lsp_pwm_channel.sv
// module: one pwm generator with duty dimming
`timescale 1ns/1ps
module lsp_pwm_channel #(
  parameter int DUTY_W = lsp_pkg::DUTY_W
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              tick_2m,
  input  wire logic              dim_tick,
  input  wire logic [DUTY_W-1:0] duty_target,
  input  wire logic              duty_ramp,
  output logic                   pwm_on,
  output logic      [DUTY_W-1:0] duty_now
);

  logic [6:0]        phase_reg;
  logic [6:0]        phase_next;
  logic [DUTY_W-1:0] duty_reg;
  logic [DUTY_W-1:0] duty_next;
  logic              on_reg;
  logic              on_next;
  logic [7:0]        duty_step;

  // phase counter over 95 ticks of 2 MHz
  assign phase_next = !tick_2m ? phase_reg :
                      (phase_reg == lsp_pkg::PWM_PERIOD - 7'h01) ? 7'h00 :
                      phase_reg + 7'h01;

  // duty: instant when dimming off, else one step per dim tick
  assign duty_step = lsp_pkg::step_toward({1'b0, duty_reg}, {1'b0, duty_target});
  assign duty_next = !duty_ramp ? duty_target :
                     dim_tick   ? duty_step[DUTY_W-1:0] : duty_reg;

  // zero off, 95 and above always on, else on while phase below duty
  assign on_next = (duty_reg >= lsp_pkg::PWM_PERIOD) ? 1'b1 :
                   (duty_reg == lsp_pkg::DUTY_OFF)   ? 1'b0 :
                   (phase_reg < duty_reg);

  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 7'h00;
      duty_reg  <= '0;
      on_reg    <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      duty_reg  <= duty_next;
      on_reg    <= on_next;
    end
  end

  assign pwm_on   = on_reg;
  assign duty_now = duty_reg;

  a_period_wrap: assert property (@(posedge clk) disable iff (!rstn)
    tick_2m && phase_reg == 7'h5E |=> phase_reg == 7'h00)
    else $error("pwm phase did not wrap after 95 ticks");

  a_phase_bound: assert property (@(posedge clk) disable iff (!rstn)
    phase_reg < 7'h5F)
    else $error("pwm phase beyond period");

  a_full_on: assert property (@(posedge clk) disable iff (!rstn)
    duty_reg >= 7'h5F |=> pwm_on)
    else $error("full duty did not hold output on");

  a_zero_off: assert property (@(posedge clk) disable iff (!rstn)
    duty_reg == 7'h00 |=> !pwm_on)
    else $error("zero duty did not hold output off");

  a_dim_hold: assert property (@(posedge clk) disable iff (!rstn)
    duty_ramp && !dim_tick |=> $stable(duty_now))
    else $error("dimmed duty moved without a dim tick");

  a_dim_up_step: assert property (@(posedge clk) disable iff (!rstn)
    duty_ramp && dim_tick && duty_now < duty_target
    |=> duty_now == $past(duty_now) + 7'h01)
    else $error("dimmed duty did not step by one");

  a_instant_duty: assert property (@(posedge clk) disable iff (!rstn)
    !duty_ramp |=> duty_now == $past(duty_target))
    else $error("undimmed duty did not apply at once");

endmodule : lsp_pwm_channel

// File: verif/tb.sv
// testbench: register table, sink enables, ramping, pwm duty and dimming of the led sink block
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("unexpected at %0t: %s got %0h exp %0h", $time, msg, got, exp); \
    end \
  end
module tb;
  // small counts keep the run short; all expectations follow from them
  localparam int PRE = 4;
  localparam int RMP = 4;
  localparam int DIM = 8;
  localparam int PER = 95 * PRE;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } lsp_tb_row_t;

  logic                  clk;
  logic                  rstn;
  lsp_pkg::lsp_bus_req_t req;
  logic [7:0]            rdata;
  logic                  phase;
  logic                  boost_mode;
  lsp_pkg::lsp_sink_t    sink1_out;
  lsp_pkg::lsp_sink_t    sink2_out;
  lsp_pkg::lsp_sink_t    sink3_out;
  int                    fail_count;
  int                    tests_run;
  int                    cycles;
  int                    hi;
  int                    bad;
  int                    n;
  logic [7:0]            rd;
  logic [7:0]            old;
  lsp_tb_row_t           rows [12];
  logic [6:0]            duties [6];
  int                    highs [6];

  lsp_led_sink_pwm_control #(
    .PRESCALE_CYC  (PRE),
    .RAMP_TICKS_2M (RMP),
    .DIM_TICKS_2M  (DIM)
  ) u_dut (
    .clk                (clk),
    .rstn               (rstn),
    .bus_req            (req),
    .rdata              (rdata),
    .sink3_pwm_phase    (phase),
    .boost_current_mode (boost_mode),
    .sink1_out          (sink1_out),
    .sink2_out          (sink2_out),
    .sink3_out          (sink3_out)
  );

  // clock generation
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= {1'b0, idx};
    req.wdata <= d;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask : wr_reg

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= {1'b0, idx};
    @(posedge clk);
    req.rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  // let registered outputs settle
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // one pwm period of channel one: high count and drive mismatches
  task automatic measure(input logic [7:0] on_c, input logic [7:0] off_c);
    hi  = 0;
    bad = 0;
    repeat (PER) begin
      @(negedge clk);
      if (sink1_out.pwm_on === 1'b1) hi++;
      if (sink1_out.drive_code !== (sink1_out.pwm_on ? on_c : off_c)) bad++;
    end
  endtask : measure

  // closing report
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    rstn = 1'b0; req = '0; phase = 1'b0;
    fail_count = 0; tests_run = 0; cycles = 0;
    rows = '{'{8'h48, 8'h5A, 8'h5A}, '{8'h49, 8'hA5, 8'hA5}, '{8'h4A, 8'h3C, 8'h3C},
             '{8'h4B, 8'hC3, 8'hC3}, '{8'h4C, 8'h10, 8'h10}, '{8'h4D, 8'h5F, 8'h5F},
             '{8'h46, 8'h77, 8'h00}, '{8'h47, 8'hBF, 8'hAF}, '{8'h47, 8'hFF, 8'hFF},
             '{8'h50, 8'h07, 8'h07}, '{8'h47, 8'hFE, 8'hFE}, '{8'h50, 8'h07, 8'h06}};
    duties = '{7'h00, 7'h01, 7'h10, 7'h5E, 7'h5F, 7'h7F};
    highs  = '{0, PRE, 16 * PRE, 94 * PRE, PER, PER};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // register table: write then read back
    foreach (rows[i]) begin
      wr_reg(rows[i].idx, rows[i].wd);
      rd_reg(rows[i].idx, rd);
      `CHK(rd, rows[i].exp, "readback")
    end
    settle();
    `CHK(boost_mode, 1'b1, "drive mode")
    `CHK(sink2_out.drive_code, 8'h3C, "ch2 always on code")
    $display("test register table done");
    // disabling a sink drops its loop inclusion
    wr_reg(8'h47, 8'hFF);
    wr_reg(8'h50, 8'h07);
    settle();
    `CHK({sink1_out.sink_enable, sink1_out.loop_include}, 2'b11, "ch1 on")
    wr_reg(8'h47, 8'hFA);
    settle();
    `CHK({sink1_out.sink_enable, sink1_out.loop_include}, 2'b00, "ch1 off")
    `CHK(sink2_out.loop_include, 1'b0, "ch2 loop off")
    rd_reg(8'h50, rd);
    `CHK(rd, 8'h04, "loop bits cleared")
    $display("test sink disable done");
    // duty codes: high time per period and code selection
    wr_reg(8'h47, 8'hFD);
    foreach (duties[i]) begin
      wr_reg(8'h4C, {1'b0, duties[i]});
      repeat (PER + 20) @(posedge clk);
      measure(8'hA5, 8'h5A);
      `CHK(hi, highs[i], "duty high count")
      `CHK(bad, 0, "active or idle code")
    end
    $display("test duty table done");
    // current ramp: immediate without ramp bit, one step per ms with it
    wr_reg(8'h4C, 8'h5F);
    wr_reg(8'h49, 8'h20);
    settle();
    `CHK(sink1_out.drive_code, 8'h20, "immediate code")
    wr_reg(8'h47, 8'hFF);
    wr_reg(8'h49, 8'h24);
    old = sink1_out.drive_code;
    n = 0;
    while (sink1_out.drive_code === old && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(sink1_out.drive_code, 8'h21, "first ramp step")
    old = sink1_out.drive_code;
    n = 0;
    while (sink1_out.drive_code === old && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, PRE * RMP, "ramp step spacing")
    `CHK(sink1_out.drive_code, 8'h22, "second ramp step")
    repeat (3 * PRE * RMP) @(posedge clk);
    @(negedge clk);
    `CHK(sink1_out.drive_code, 8'h24, "ramp target")
    wr_reg(8'h49, 8'h22);
    repeat (3 * PRE * RMP) @(posedge clk);
    @(negedge clk);
    `CHK(sink1_out.drive_code, 8'h22, "ramp down target")
    $display("test current ramp done");
    // duty dimming from full on down to sixteen
    wr_reg(8'h4C, 8'h90);
    measure(8'h22, 8'h5A);
    `CHK(hi > 16 * PRE, 1'b1, "dimming still high")
    repeat (80 * PRE * DIM) @(posedge clk);
    measure(8'h22, 8'h5A);
    `CHK(hi, 16 * PRE, "dimmed duty")
    wr_reg(8'h4C, 8'h94);
    repeat (5 * PRE * DIM) @(posedge clk);
    measure(8'h22, 8'h5A);
    `CHK(hi, 20 * PRE, "dimmed duty up")
    `CHK(bad, 0, "dimmed codes")
    $display("test duty dimming done");
    // shared idle code on channel two
    wr_reg(8'h4D, 8'h00);
    settle();
    `CHK({sink2_out.pwm_on, sink2_out.drive_code}, 9'h05A, "ch2 idle")
    wr_reg(8'h48, 8'h66);
    settle();
    `CHK(sink2_out.drive_code, 8'h66, "new idle code")
    $display("test idle code done");
    // channel three: current controlled, then pwm only
    @(posedge clk);
    phase <= 1'b1;
    wr_reg(8'h47, 8'hFF);
    wr_reg(8'h50, 8'h07);
    settle();
    `CHK(sink3_out, {3'b111, 8'hC3}, "ch3 duty")
    @(posedge clk);
    phase <= 1'b0;
    settle();
    `CHK(sink3_out.drive_code, 8'h66, "ch3 idle")
    @(posedge clk);
    phase <= 1'b1;
    wr_reg(8'h47, 8'hBF);
    settle();
    `CHK({sink3_out.sink_enable, sink3_out.loop_include}, 2'b00, "ch3 pwm only")
    `CHK(sink3_out.drive_code, 8'h00, "ch3 no current")
    `CHK(sink3_out.pwm_on, 1'b1, "ch3 phase")
    $display("test channel three done");
    // reset in mid-run clears everything
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK({boost_mode, sink1_out, sink2_out, sink3_out}, 34'h0, "outputs in reset")
    @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      rd_reg(rows[i].idx, rd);
      `CHK(rd, 8'h00, "reset value")
    end
    $display("test reset done");
    print_verdict();
  end
endmodule : tb
